//--- logic/dadc_ddr_out.v
// double data rate output stage for both channels and the shared flag
// assumes word and phase come from the same clk domain
`timescale 1ns/1ps
`default_nettype none

module dadc_ddr_out #(
	parameter PAIRS = 6 // output pairs per channel
) (
	// clock and reset
	input  wire               clk,
	input  wire               reset,
	// aligned sample and phase
	input  wire [2*PAIRS-1:0] word_a,
	input  wire [2*PAIRS-1:0] word_b,
	input  wire               over_a,
	input  wire               over_b,
	input  wire               phase_high,
	// registered pin levels
	output reg  [PAIRS-1:0]   chan_a_bit_pair,
	output reg  [PAIRS-1:0]   chan_b_bit_pair,
	output reg                range_flag_out,
	output reg                clock_level
);

	reg [PAIRS-1:0] next_a; // next pair levels, channel a
	reg [PAIRS-1:0] next_b; // next pair levels, channel b
	integer         i;      // pair index

	// even bits while low, odd bits while high
	always @* begin
		next_a = {PAIRS{1'b0}};
		next_b = {PAIRS{1'b0}};
		for (i = 0; i < PAIRS; i = i + 1) begin
			next_a[i] = phase_high ? word_a[2*i+1] : word_a[2*i];
			next_b[i] = phase_high ? word_b[2*i+1] : word_b[2*i];
		end
	end

	// one register stage for data and clock keeps edges aligned
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			chan_a_bit_pair <= {PAIRS{1'b0}};
			chan_b_bit_pair <= {PAIRS{1'b0}};
			range_flag_out  <= 1'b0;
			clock_level     <= 1'b0;
		end else begin
			chan_a_bit_pair <= next_a;
			chan_b_bit_pair <= next_b;
			range_flag_out  <= phase_high ? over_b : over_a;
			clock_level     <= phase_high;
		end
	end

endmodule // dadc_ddr_out

`default_nettype wire

//--- logic/dadc_spi_port.v
// serial configuration port: shifter, mode control registers, readback
// assumes cs_n, sdi already synchronised and sck edges found in clk domain
`timescale 1ns/1ps
`default_nettype none
`include "dadc_consts.vh"

module dadc_spi_port (
	// clock and reset
	input  wire       clk,
	input  wire       reset,
	// serial pins after synchronisation
	input  wire       enable,
	input  wire       cs_n,
	input  wire       sck_rise,
	input  wire       sck_fall,
	input  wire       sdi,
	// open-drain readback, low enable pulls the line low
	output reg        sdo_oe_n,
	// mode control registers
	output reg  [7:0] reg_power,
	output reg  [7:0] reg_clock,
	output reg  [7:0] reg_output
);

	reg  [15:0] shift_in;  // incoming frame
	reg  [4:0]  bit_count; // bits taken this frame
	reg  [7:0]  shift_out; // readback bits still to send
	reg         reading;   // frame is a read
	wire        take;      // one bit is taken this cycle
	wire [15:0] frame;     // frame including the bit now taken

	// decode of readback value, unmapped addresses read zero
	function [7:0] read_mux;
		input [6:0] addr;
		input [7:0] p;
		input [7:0] c;
		input [7:0] o;
		begin
			case (addr)
				`DADC_ADDR_POWER:  read_mux = p;
				`DADC_ADDR_CLOCK:  read_mux = c;
				`DADC_ADDR_OUTPUT: read_mux = o;
				default:           read_mux = 8'h00;
			endcase
		end
	endfunction

	// edges only count in serial mode and with cs_n low
	assign take  = enable && !cs_n && sck_rise && (bit_count < `DADC_FRAME_BITS);
	assign frame = {shift_in[14:0], sdi};

	// shifter and register writes
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			shift_in   <= 16'h0000;
			bit_count  <= 5'h00;
			reading    <= 1'b0;
			reg_power  <= `DADC_RST_POWER;
			reg_clock  <= `DADC_RST_CLOCK;
			reg_output <= `DADC_RST_OUTPUT;
		end else if (!enable || cs_n) begin
			// a deselect ends the frame; a partial frame writes nothing
			bit_count <= 5'h00;
			reading   <= 1'b0;
		end else if (take) begin
			shift_in  <= frame;
			bit_count <= bit_count + 5'h01;
			if (bit_count == 5'h00) begin
				reading <= sdi;
			end
			// the sixteenth bit completes a write
			if (bit_count == `DADC_FRAME_BITS - 5'h01 && !reading) begin
				case (frame[14:8])
					`DADC_ADDR_POWER:  reg_power  <= frame[7:0];
					`DADC_ADDR_CLOCK:  reg_clock  <= frame[7:0];
					`DADC_ADDR_OUTPUT: reg_output <= frame[7:0];
					default:           reg_power  <= reg_power;
				endcase
			end
		end
	end

	// readback: load after address, change sdo on each falling sck
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			shift_out <= 8'h00;
			sdo_oe_n  <= 1'b1;
		end else if (!enable || cs_n) begin
			shift_out <= 8'h00;
			sdo_oe_n  <= 1'b1;
		end else if (take && bit_count == `DADC_ADDR_BITS - 5'h01 && reading) begin
			shift_out <= read_mux(frame[6:0], reg_power, reg_clock, reg_output);
		end else if (sck_fall && reading && bit_count >= `DADC_ADDR_BITS) begin
			// pull low for a zero, release for a one
			sdo_oe_n  <= shift_out[7];
			shift_out <= {shift_out[6:0], 1'b0};
		end
	end

endmodule // dadc_spi_port

`default_nettype wire

//--- logic/dadc_top.v
// top of the converter digital side: pin sampling, programming mode,
// clock regeneration, pipeline and the ddr output path
// assumes the core results arrive on clk, one per sample_strobe
`timescale 1ns/1ps
`default_nettype none
`include "dadc_consts.vh"

module dadc_top #(
	parameter RES   = `DADC_RES_BITS,   // result width
	parameter DEPTH = `DADC_PIPE_DEPTH, // pipeline latency in samples
	parameter CNT_W = 8                 // encode period counter width
) (
	// clock and reset
	input  wire           clk,
	input  wire           reset,
	// encode pin
	input  wire           sample_clock_in,
	// core results, same clock
	input  wire [RES-1:0] conv_a_data,
	input  wire [RES-1:0] conv_b_data,
	input  wire           conv_a_over,
	input  wire           conv_b_over,
	output reg            sample_strobe,
	// programming pins
	input  wire           prog_mode_strap,
	input  wire           spi_cs_n,
	input  wire           spi_sck,
	input  wire           spi_sdi,
	output wire           spi_sdo_out,
	output wire           spi_sdo_oe_n,
	// ddr outputs
	output wire [RES/2-1:0] chan_a_bit_pair,
	output wire [RES/2-1:0] chan_b_bit_pair,
	output wire           range_flag_out,
	output reg            forwarded_out_clock,
	// mode levels to the analog side
	output reg  [2:0]     drive_current_code,
	output reg            term_enable,
	output reg            outputs_disable,
	output reg            power_sleep,
	output reg            power_nap,
	output reg            chan_b_off,
	output reg            dcs_enable,
	output reg            serial_mode
);

	// synchroniser stages, first stage read only by the second
	reg       enc_m;        // encode, first stage
	reg       enc_s;        // encode, second stage
	reg       enc_d;        // encode, edge history
	reg       enc_q;        // encode, aligned with the pipeline tail
	reg       cs_m;         // chip select, first stage
	reg       cs_s;         // chip select, second stage
	reg       sck_m;        // serial clock, first stage
	reg       sck_s;        // serial clock, second stage
	reg       sck_d;        // serial clock, edge history
	reg       sdi_m;        // data in, first stage
	reg       sdi_s;        // data in, second stage
	reg       strap_m;      // strap, first stage
	reg       strap_s;      // strap, second stage
	reg       strap_taken;  // strap has been latched
	wire      enc_rise;     // encode rising edge found
	wire      sck_rise;     // serial clock rising edge
	wire      sck_fall;     // serial clock falling edge

	// register file from the serial port
	wire [7:0] reg_power;   // sleep, nap, channel b off
	wire [7:0] reg_clock;   // clock_config_reg
	wire [7:0] reg_output;  // current, termination, disable

	// encode period measurement and regenerated clock
	reg  [CNT_W-1:0] phase_cnt;  // clk cycles since last encode rise
	reg  [CNT_W-1:0] period;     // last measured encode period
	reg              period_ok;  // an encode rise has been seen
	wire [CNT_W-1:0] half;       // half period for fifty percent
	wire [CNT_W-1:0] step;       // one eighth period, 45 degrees
	wire [CNT_W-1:0] shift_cyc;  // programmed clock delay
	wire [CNT_W-1:0] pos;        // delayed phase position
	wire             regen_high; // undelayed regenerated clock
	wire             data_high;  // phase that steers the data mux
	wire             clk_high;   // phase of forwarded clock

	// pipeline storage, index 0 newest
	reg [RES-1:0] pipe_a [0:DEPTH-1]; // channel a words
	reg [RES-1:0] pipe_b [0:DEPTH-1]; // channel b words
	reg [DEPTH-1:0] pipe_oa;          // channel a range flags
	reg [DEPTH-1:0] pipe_ob;          // channel b range flags
	reg           cap_pending;        // core results taken at the end of this cycle
	integer       k;                  // pipeline index

	// wrap a position back into one encode period
	function [CNT_W-1:0] wrap_sub;
		input [CNT_W-1:0] a;
		input [CNT_W-1:0] b;
		input [CNT_W-1:0] per;
		begin
			if (a >= b) begin
				wrap_sub = a - b;
			end else begin
				wrap_sub = a + per - b;
			end
		end
	endfunction

	// two stages on every pin before logic sees it
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			enc_m   <= 1'b0;
			enc_s   <= 1'b0;
			enc_d   <= 1'b0;
			cs_m    <= 1'b1;
			cs_s    <= 1'b1;
			sck_m   <= 1'b0;
			sck_s   <= 1'b0;
			sck_d   <= 1'b0;
			sdi_m   <= 1'b0;
			sdi_s   <= 1'b0;
			enc_q   <= 1'b0;
		end else begin
			enc_m   <= sample_clock_in;
			enc_s   <= enc_m;
			enc_d   <= enc_s;
			cs_m    <= spi_cs_n;
			cs_s    <= cs_m;
			sck_m   <= spi_sck;
			sck_s   <= sck_m;
			sck_d   <= sck_s;
			sdi_m   <= spi_sdi;
			sdi_s   <= sdi_m;
			enc_q   <= enc_d;
		end
	end

	// strap stages run through reset so the latch after release sees
	// the board level, not a reset value
	always @(posedge clk) begin
		strap_m <= prog_mode_strap;
		strap_s <= strap_m;
	end

	// conversions start on the rising edge of the true encode input
	assign enc_rise = enc_s && !enc_d;
	assign sck_rise = sck_s && !sck_d;
	assign sck_fall = !sck_s && sck_d;

	// strap caught once after release; the board never moves it, so a
	// later change is deliberately ignored rather than followed
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_taken <= 1'b0;
			serial_mode <= 1'b1;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			serial_mode <= !strap_s;
		end
	end

	// serial port and its registers
	dadc_spi_port u_spi (
		.clk        (clk),
		.reset      (reset),
		.enable     (serial_mode && strap_taken),
		.cs_n       (cs_s),
		.sck_rise   (sck_rise),
		.sck_fall   (sck_fall),
		.sdi        (sdi_s),
		.sdo_oe_n   (spi_sdo_oe_n),
		.reg_power  (reg_power),
		.reg_clock  (reg_clock),
		.reg_output (reg_output)
	);

	// open drain: the pin only ever pulls low
	assign spi_sdo_out = 1'b0;

	// mode levels come from registers in serial mode, pins in parallel
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			drive_current_code <= `DADC_CUR_3P5MA;
			term_enable        <= 1'b0;
			outputs_disable    <= 1'b0;
			power_sleep        <= 1'b0;
			power_nap          <= 1'b0;
			chan_b_off         <= 1'b0;
			dcs_enable         <= 1'b1;
		end else if (serial_mode) begin
			drive_current_code <= reg_output[`DADC_OUT_CUR_HI:`DADC_OUT_CUR_LO];
			term_enable        <= reg_output[`DADC_OUT_TERM];
			outputs_disable    <= reg_output[`DADC_OUT_DIS];
			power_sleep        <= reg_power[`DADC_PWR_SLEEP];
			power_nap          <= reg_power[`DADC_PWR_NAP];
			chan_b_off         <= reg_power[`DADC_PWR_BOFF];
			dcs_enable         <= reg_clock[`DADC_CLK_DCS];
		end else begin
			// parallel mode reaches only a reduced set of modes
			drive_current_code <= sdi_s ? `DADC_CUR_1P75MA : `DADC_CUR_3P5MA;
			term_enable        <= 1'b0;
			outputs_disable    <= 1'b0;
			power_sleep        <= sck_s;
			power_nap          <= 1'b0;
			chan_b_off         <= 1'b0;
			dcs_enable         <= cs_s;
		end
	end

	// measure the encode period in clk cycles, rise to rise
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			phase_cnt <= {CNT_W{1'b0}};
			period    <= {CNT_W{1'b0}};
			period_ok <= 1'b0;
		end else if (enc_rise) begin
			phase_cnt <= {CNT_W{1'b0}};
			period    <= phase_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
			period_ok <= 1'b1;
		end else if (phase_cnt != {CNT_W{1'b1}}) begin
			// saturate so a stopped encode clock cannot wrap
			phase_cnt <= phase_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// stabilizer: high for half the last period whatever the duty
	assign half       = {1'b0, period[CNT_W-1:1]};
	// rises in the cycle after the pipeline tail takes a new word
	assign regen_high = period_ok && (phase_cnt != {CNT_W{1'b0}}) &&
		(phase_cnt <= half);
	assign data_high  = dcs_enable ? regen_high : enc_q;

	// phase shift in eighths of a period, only with the stabilizer on
	assign step       = {3'b000, period[CNT_W-1:3]};
	assign shift_cyc  = step * {{(CNT_W-2){1'b0}},
		reg_clock[`DADC_CLK_PH_HI:`DADC_CLK_PH_LO]};
	assign pos        = wrap_sub(phase_cnt, shift_cyc, period);
	assign clk_high   = dcs_enable && serial_mode ?
		(period_ok && pos != {CNT_W{1'b0}} && pos <= half) : enc_q;

	// one encode edge samples both channels together
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sample_strobe <= 1'b0;
			cap_pending   <= 1'b0;
		end else begin
			sample_strobe <= enc_rise && !power_sleep;
			cap_pending   <= enc_rise && !power_sleep;
		end
	end

	// data and flags share the same stages, one step per sample
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			for (k = 0; k < DEPTH; k = k + 1) begin
				pipe_a[k] <= {RES{1'b0}};
				pipe_b[k] <= {RES{1'b0}};
			end
			pipe_oa <= {DEPTH{1'b0}};
			pipe_ob <= {DEPTH{1'b0}};
		end else if (cap_pending) begin
			pipe_a[0] <= conv_a_data;
			pipe_b[0] <= chan_b_off ? {RES{1'b0}} : conv_b_data;
			pipe_oa   <= {pipe_oa[DEPTH-2:0], conv_a_over};
			pipe_ob   <= {pipe_ob[DEPTH-2:0], conv_b_over && !chan_b_off};
			for (k = 1; k < DEPTH; k = k + 1) begin
				pipe_a[k] <= pipe_a[k-1];
				pipe_b[k] <= pipe_b[k-1];
			end
		end
	end

	// ddr stage drives pairs and flag from the pipeline tail
	dadc_ddr_out #(
		.PAIRS (RES/2)
	) u_ddr (
		.clk             (clk),
		.reset           (reset),
		.word_a          (pipe_a[DEPTH-1]),
		.word_b          (pipe_b[DEPTH-1]),
		.over_a          (pipe_oa[DEPTH-1]),
		.over_b          (pipe_ob[DEPTH-1]),
		.phase_high      (data_high),
		.chan_a_bit_pair (chan_a_bit_pair),
		.chan_b_bit_pair (chan_b_bit_pair),
		.range_flag_out  (range_flag_out),
		.clock_level     ()
	);

	// forwarded clock: one register from the phase, like the data, so
	// both move on one edge unless a shift is programmed;
	// inversion applies independently of the shift
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			forwarded_out_clock <= 1'b0;
		end else if (shift_cyc == {CNT_W{1'b0}} || !dcs_enable) begin
			forwarded_out_clock <= data_high ^ (serial_mode && reg_clock[`DADC_CLK_INV]);
		end else begin
			forwarded_out_clock <= clk_high ^ reg_clock[`DADC_CLK_INV];
		end
	end

endmodule // dadc_top

`default_nettype wire

//--- pkg/dadc_consts.vh
// constants shared by the dual converter control logic
// assumes one clk domain at 250 MHz; included by bare name
`ifndef DADC_CONSTS_VH
`define DADC_CONSTS_VH

// serial frame layout: rw bit, 7 address bits, 8 data bits
`define DADC_FRAME_BITS   5'h10
`define DADC_ADDR_BITS    5'h08
// mode control register addresses
`define DADC_ADDR_POWER   7'h01
`define DADC_ADDR_CLOCK   7'h02
`define DADC_ADDR_OUTPUT  7'h03
// reset values
`define DADC_RST_POWER    8'h00
`define DADC_RST_CLOCK    8'h01
`define DADC_RST_OUTPUT   8'h00
// power register fields
`define DADC_PWR_SLEEP    0
`define DADC_PWR_NAP      1
`define DADC_PWR_BOFF     2
// clock_config_reg fields
`define DADC_CLK_DCS      0
`define DADC_CLK_PH_LO    1
`define DADC_CLK_PH_HI    2
`define DADC_CLK_INV      3
// output register fields
`define DADC_OUT_CUR_LO   0
`define DADC_OUT_CUR_HI   2
`define DADC_OUT_TERM     3
`define DADC_OUT_DIS      4
// driver current codes
`define DADC_CUR_3P5MA    3'h0
`define DADC_CUR_1P75MA   3'h7
// result width and pipeline depth in samples
`define DADC_RES_BITS     12
`define DADC_PIPE_DEPTH   5

`endif

//--- tb/dadc_properties.sv
// checker for the converter top: mode pins, serial port, ddr timing
// assumes the bind at the foot attaches it to every top instance
`timescale 1ns/1ps
`default_nettype none
`include "dadc_consts.vh"

module dadc_properties #(
	parameter RES = `DADC_RES_BITS // result width
) (
	// clock and reset
	input wire logic             clk,
	input wire logic             reset,
	// encode and programming pins
	input wire logic             sample_clock_in,
	input wire logic             prog_mode_strap,
	input wire logic             spi_cs_n,
	input wire logic             spi_sck,
	input wire logic             spi_sdi,
	// design outputs
	input wire logic             sample_strobe,
	input wire logic             spi_sdo_out,
	input wire logic             spi_sdo_oe_n,
	input wire logic [RES/2-1:0] chan_a_bit_pair,
	input wire logic [RES/2-1:0] chan_b_bit_pair,
	input wire logic             range_flag_out,
	input wire logic             forwarded_out_clock,
	input wire logic [2:0]       drive_current_code,
	input wire logic             power_sleep,
	input wire logic             dcs_enable,
	input wire logic             serial_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// encode rise, still awake when the strobe is decided two edges on
	sequence s_enc_rise;
		$rose(sample_clock_in) ##2 !power_sleep;
	endsequence
	// chip select idle long enough to pass the synchroniser
	sequence s_cs_idle;
		spi_cs_n [*5];
	endsequence

	property p_enc_strobe;
		s_enc_rise |=> sample_strobe;
	endproperty
	a_enc_strobe: assert property (p_enc_strobe) else $error("no strobe after encode rise");
	property p_strobe_once;
		sample_strobe |=> !sample_strobe ##1 !sample_strobe;
	endproperty
	a_strobe_once: assert property (p_strobe_once) else $error("strobe longer than a pulse");
	// strap read once after release; the level it picks must hold
	property p_mode_strap;
		!$past(reset) |-> serial_mode != prog_mode_strap;
	endproperty
	a_mode_strap: assert property (p_mode_strap) else $error("mode differs from strap");
	property p_mode_fixed;
		!$past(reset) && !$past(reset, 2) |-> $stable(serial_mode);
	endproperty
	a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed in run");
	property p_par_current;
		!serial_mode && $rose(spi_sdi) |-> ##[1:6] drive_current_code == `DADC_CUR_1P75MA;
	endproperty
	a_par_current: assert property (p_par_current) else $error("data pin did not set current");
	property p_par_sleep;
		!serial_mode && $rose(spi_sck) |-> ##[1:6] power_sleep;
	endproperty
	a_par_sleep: assert property (p_par_sleep) else $error("clock pin did not set sleep");
	property p_par_dcs;
		!serial_mode && $fell(spi_cs_n) |-> ##[1:6] !dcs_enable;
	endproperty
	a_par_dcs: assert property (p_par_dcs) else $error("select pin did not clear dcs");
	// edges with chip select high must leave drive_current_code and dcs_enable alone
	property p_ser_ignore;
		(serial_mode && spi_cs_n) [*8] |=> $stable(drive_current_code) && $stable(dcs_enable);
	endproperty
	a_ser_ignore: assert property (p_ser_ignore) else $error("mode changed without select");
	property p_ddr_edges;
		$changed({chan_a_bit_pair, chan_b_bit_pair, range_flag_out})
			|-> $changed(forwarded_out_clock);
	endproperty
	a_ddr_edges: assert property (p_ddr_edges) else $error("data moved off a clock edge");
	property p_sdo_idle;
		s_cs_idle |-> spi_sdo_oe_n && !spi_sdo_out;
	endproperty
	a_sdo_idle: assert property (p_sdo_idle) else $error("readback line held without select");
	property p_sdo_fall;
		!spi_cs_n && $changed(spi_sdo_oe_n) |-> !spi_sck;
	endproperty
	a_sdo_fall: assert property (p_sdo_fall) else $error("readback moved with clock high");
endmodule // dadc_properties

bind dadc_top dadc_properties #(.RES(RES)) i_dadc_properties (
	.clk(clk), .reset(reset), .sample_clock_in(sample_clock_in),
	.prog_mode_strap(prog_mode_strap), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
	.spi_sdi(spi_sdi), .sample_strobe(sample_strobe), .spi_sdo_out(spi_sdo_out),
	.spi_sdo_oe_n(spi_sdo_oe_n), .chan_a_bit_pair(chan_a_bit_pair),
	.chan_b_bit_pair(chan_b_bit_pair), .range_flag_out(range_flag_out),
	.forwarded_out_clock(forwarded_out_clock), .drive_current_code(drive_current_code),
	.power_sleep(power_sleep), .dcs_enable(dcs_enable), .serial_mode(serial_mode)
);
`default_nettype wire

//--- tb/dadc_rx_model.sv
// receiver model: rebuilds words from the ddr pairs
// assumes it samples the registered pins on the design clock
`timescale 1ns/1ps
`default_nettype none

module dadc_rx_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// ddr pins
	input  wire logic [5:0] chan_a_bit_pair,
	input  wire logic [5:0] chan_b_bit_pair,
	input  wire logic       range_flag_out,
	input  wire logic       forwarded_out_clock,
	// rebuilt sample, got pulses once a word
	output logic [11:0]     word_a,
	output logic [11:0]     word_b,
	output logic            flag_a,
	output logic            flag_b,
	output logic            got,
	// cycles spent at each clock level
	output logic [7:0]      hi_len,
	output logic [7:0]      lo_len
);
	logic       prev;  // last clock level
	logic [7:0] run;   // cycles at current level
	logic [5:0] odd_a; // odd bits held from high phase
	logic [5:0] odd_b;
	integer     i;

	// high phase gives odd bits and b flag; the fall closes the word
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			prev <= 1'b0;
			run <= 8'h00;
			got <= 1'b0;
		end else begin
			got <= 1'b0;
			prev <= forwarded_out_clock;
			run <= (forwarded_out_clock == prev) ? run + 8'h01 : 8'h01;
			if (forwarded_out_clock) begin
				odd_a <= chan_a_bit_pair;
				odd_b <= chan_b_bit_pair;
				flag_b <= range_flag_out;
			end
			if (prev && !forwarded_out_clock) begin
				for (i = 0; i < 6; i = i + 1) begin
					word_a[2*i] <= chan_a_bit_pair[i];
					word_a[2*i+1] <= odd_a[i];
					word_b[2*i] <= chan_b_bit_pair[i];
					word_b[2*i+1] <= odd_b[i];
				end
				flag_a <= range_flag_out;
				hi_len <= run;
				got <= 1'b1;
			end
			if (!prev && forwarded_out_clock)
				lo_len <= run;
		end
	end
endmodule // dadc_rx_model
`default_nettype wire

//--- tb/tb.sv
// bench: parallel levels, serial frames and the ddr data path
// assumes the receiver model and the bound checker compile alongside
`timescale 1ns/1ps
`default_nettype none
`include "dadc_consts.vh"

module tb;
	// pins and counters
	logic        clk = 1'b0, reset = 1'b1, sample_clock_in = 1'b0;
	logic [11:0] conv_a_data = 12'h000, conv_b_data = 12'h000, n = 12'h000;
	logic        conv_a_over = 1'b0, conv_b_over = 1'b0, prog_mode_strap = 1'b1;
	logic        spi_cs_n = 1'b1, spi_sck = 1'b0, spi_sdi = 1'b0;
	wire logic   sample_strobe, spi_sdo_out, spi_sdo_oe_n, range_flag_out;
	wire logic   forwarded_out_clock, term_enable, power_sleep, dcs_enable, serial_mode;
	wire logic [5:0] chan_a_bit_pair, chan_b_bit_pair;
	wire logic [2:0] drive_current_code;
	wire logic [11:0] word_a, word_b;
	wire logic [7:0]  hi_len, lo_len;
	wire logic   flag_a, flag_b, got;
	real         enc_hi = 16.3; // encode high time, ns
	int          fail_count = 0, comparisons = 0, cycles = 0;

	dadc_top i_dadc_top (.clk(clk), .reset(reset), .sample_clock_in(sample_clock_in),
		.conv_a_data(conv_a_data), .conv_b_data(conv_b_data), .conv_a_over(conv_a_over),
		.conv_b_over(conv_b_over), .sample_strobe(sample_strobe),
		.prog_mode_strap(prog_mode_strap), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
		.spi_sdi(spi_sdi), .spi_sdo_out(spi_sdo_out), .spi_sdo_oe_n(spi_sdo_oe_n),
		.chan_a_bit_pair(chan_a_bit_pair), .chan_b_bit_pair(chan_b_bit_pair),
		.range_flag_out(range_flag_out), .forwarded_out_clock(forwarded_out_clock),
		.drive_current_code(drive_current_code), .term_enable(term_enable),
		.outputs_disable(), .power_sleep(power_sleep), .power_nap(), .chan_b_off(),
		.dcs_enable(dcs_enable), .serial_mode(serial_mode));
	dadc_rx_model i_dadc_rx_model (.clk(clk), .reset(reset),
		.chan_a_bit_pair(chan_a_bit_pair), .chan_b_bit_pair(chan_b_bit_pair),
		.range_flag_out(range_flag_out), .forwarded_out_clock(forwarded_out_clock),
		.word_a(word_a), .word_b(word_b), .flag_a(flag_a), .flag_b(flag_b),
		.got(got), .hi_len(hi_len), .lo_len(lo_len));

	// 250 MHz clock
	always #2 clk = ~clk;
	// encode pin, 32 ns period, off grid so unrelated in phase
	always begin
		#(32.0 - enc_hi) sample_clock_in = 1'b1;
		#(enc_hi) sample_clock_in = 1'b0;
	end
	// new result each strobe; b is the complement, flags follow bit 0
	always @(negedge clk) begin
		if (sample_strobe === 1'b1) begin
			n = n + 12'h0A7;
			conv_a_data <= n;
			conv_b_data <= ~n;
			conv_a_over <= n[0];
			conv_b_over <= ~n[0];
		end
	end
	// hang guard, run needs about 1500 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			fail_count++;
			results();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// strap only moves while reset is held
	task automatic do_reset(input logic strap);
		@(negedge clk);
		prog_mode_strap = strap;
		reset = 1'b1;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		repeat (6) @(negedge clk);
	endtask

	// one 16 bit frame, sck halves of 8 clk; readback under a pull-up
	task automatic spi_frame(input logic cs_lvl, input logic [15:0] f, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		spi_cs_n = cs_lvl;
		for (i = 15; i >= 0; i--) begin
			spi_sdi = f[i];
			repeat (8) @(negedge clk);
			spi_sck = 1'b1;
			repeat (8) @(negedge clk);
			if (i < 8)
				rd = {rd[6:0], spi_sdo_oe_n ? 1'b1 : spi_sdo_out};
			spi_sck = 1'b0;
		end
		repeat (8) @(negedge clk);
		spi_cs_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask

	task automatic t_parallel();
		int k, w;
		do_reset(1'b1);
		check(serial_mode, 1'b0);
		spi_sdi = 1'b1;
		repeat (8) @(negedge clk);
		check(drive_current_code, `DADC_CUR_1P75MA);
		spi_sdi = 1'b0;
		repeat (8) @(negedge clk);
		check(drive_current_code, `DADC_CUR_3P5MA);
		spi_cs_n = 1'b0;
		repeat (8) @(negedge clk);
		check(dcs_enable, 1'b0);
		spi_cs_n = 1'b1;
		repeat (8) @(negedge clk);
		check(dcs_enable, 1'b1);
		spi_sck = 1'b1;
		repeat (8) @(negedge clk);
		check(power_sleep, 1'b1);
		w = 0;
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			if (sample_strobe === 1'b1)
				w++;
		end
		check(w, 0);
		spi_sck = 1'b0;
		repeat (8) @(negedge clk);
		check(power_sleep, 1'b0);
	endtask

	task automatic t_serial();
		logic [7:0] rd;
		do_reset(1'b0);
		check(serial_mode, 1'b1);
		check(dcs_enable, 1'b1);
		spi_frame(1'b0, {1'b0, `DADC_ADDR_OUTPUT, 8'h0F}, rd);
		check(drive_current_code, `DADC_CUR_1P75MA);
		check(term_enable, 1'b1);
		spi_frame(1'b1, {1'b0, `DADC_ADDR_OUTPUT, 8'h00}, rd);
		check(drive_current_code, `DADC_CUR_1P75MA);
		spi_frame(1'b0, {1'b1, `DADC_ADDR_OUTPUT, 8'h00}, rd);
		check(rd, 8'h0F);
		spi_frame(1'b0, {1'b0, `DADC_ADDR_CLOCK, 8'h00}, rd);
		check(dcs_enable, 1'b0);
	endtask

	// twenty words; the first ten fill the pipeline and settle the phase
	task automatic t_ddr(input real hi, input logic duty);
		logic [11:0] last, inv, step;
		int k, w;
		enc_hi = hi;
		last = 12'h000;
		for (k = 0; k < 20; k++) begin
			w = 0;
			do begin
				@(negedge clk);
				w++;
			end while (got !== 1'b1 && w < 40);
			inv = ~word_a;
			step = word_a - last;
			last = word_a;
			if (k >= 10) begin
				check(w < 40, 1'b1);
				check(word_b, inv);
				check(flag_a, word_a[0]);
				check(flag_b, inv[0]);
				check(step, 12'h0A7);
				if (duty) begin
					check(hi_len, 8'h04);
					check(lo_len, 8'h04);
				end
			end
		end
	endtask

	initial begin
		t_parallel();
		t_ddr(10.3, 1'b1);
		t_serial();
		t_ddr(16.3, 1'b0);
		results();
	end
endmodule // tb
`default_nettype wire
